// ---- hw/ctq_pkg.sv ----
// ctq_pkg: register map, field positions, reset values and types of the tx queue control block.
// assumes a 32-bit avalon-mm slave with word addressing; registers sit in the low 16 bits.
package ctq_pkg;

    // word indices on the avalon address
    localparam logic [2:0] A_BASE_HI = 3'h0;
    localparam logic [2:0] A_BASE_LO = 3'h1;
    localparam logic [2:0] A_CFG     = 3'h2;
    localparam logic [2:0] A_CTL     = 3'h3;
    localparam logic [2:0] A_STA     = 3'h4;
    localparam logic [2:0] A_GLB     = 3'h5;
    localparam logic [2:0] A_VEC     = 3'h6;

    // control register bits
    localparam int CTL_FLUSH  = 10;
    localparam int CTL_REQ    = 9;
    localparam int CTL_ADV    = 8;
    localparam int CTL_DIR    = 7;
    localparam int CTL_EXH_IE = 4;
    localparam int CTL_EMP_IE = 2;
    localparam int CTL_NF_IE  = 0;

    // state register bits
    localparam int STA_IDX_LSB = 8;
    localparam int STA_ABT     = 7;
    localparam int STA_ARB     = 6;
    localparam int STA_ERR     = 5;
    localparam int STA_EXH     = 4;
    localparam int STA_EMP     = 2;
    localparam int STA_NF      = 0;

    // config register field positions
    localparam int CFG_PL_LSB    = 13;
    localparam int CFG_DEPTH_LSB = 8;
    localparam int CFG_RETRY_LSB = 5;
    localparam int CFG_PRI_LSB   = 0;

    // global register and vector register bits
    localparam int GLB_MODE_LSB = 0;
    localparam int GLB_RTX      = 4;
    localparam int VEC_SUM      = 0;
    localparam int VEC_REQ      = 1;

    localparam logic [2:0]  MODE_CONFIG     = 3'h4;
    localparam logic [2:0]  MODE_RESET      = 3'h4;
    localparam logic [1:0]  RETRY_NONE      = 2'h0;
    localparam logic [1:0]  RETRY_THREE     = 2'h1;
    localparam logic [1:0]  RETRY_RESET     = 2'h3;
    localparam logic [1:0]  RETRY_MAX_TRIES = 2'h3;
    localparam logic        TX_DIR_VALUE    = 1'b0;
    localparam logic [15:0] BASE_LO_MASK    = 16'hFFFC;

    typedef struct packed {
        logic [2:0] payload_size_code;
        logic [4:0] queue_depth_code;
        logic [1:0] retry_limit_code;
        logic [4:0] transmit_priority;
    } ctq_cfg_type;

    localparam ctq_cfg_type CFG_RESET = '{3'h0, 5'h00, RETRY_RESET, 5'h00};

    // one-cycle outcome pulses from the protocol engine
    typedef struct packed {
        logic sent;
        logic aborted;
        logic arb_lost;
        logic bus_error;
    } ctq_evt_type;

    function automatic logic [6:0] payload_bytes(input logic [2:0] code);
        logic [6:0] b;
        b = 7'h08;
        unique case (code)
            3'h0: b = 7'h08;
            3'h1: b = 7'h0C;
            3'h2: b = 7'h10;
            3'h3: b = 7'h14;
            3'h4: b = 7'h18;
            3'h5: b = 7'h20;
            3'h6: b = 7'h30;
            3'h7: b = 7'h40;
        endcase
        return b;
    endfunction

endpackage

// ---- hw/ctq_top.sv ----
// ctq_top: transmit queue control and status, message memory base register, avalon-mm slave.
// assumes engine events arrive on I_CORE_CLK as one-cycle pulses; one wait state per access.
// Contract
// R1: hold 32-bit message memory base in high and low 16-bit registers.
// R2: base address bits 1:0 read zero and ignore writes.
// R3: payload code maps to 8,12,16,20,24,32,48,64 bytes.
// R4: queue depth is depth code plus one messages, 1 to 32.
// R5: with global retry enable, code 00 none, 01 three, 1x unlimited; resets 11.
// R6: 5-bit priority, 11111 highest, 00000 lowest.
// R7: payload and depth codes writable only in configuration mode 100.
// R8: flush bit resets the queue and hardware clears it when done.
// R9: send request set by software, cleared by hardware when queue drained.
// R10: software clearing a set send request asks for abort.
// R11: head advance moves the queue head by exactly one slot.
// R12: transmit direction bit 7 is read-only.
// R13: interrupt enables at bits 4, 2 and 0.
// R14: next-slot index is zero-based, range zero to depth minus one.
// R15: aborted bit set on abort, cleared on completion or flush.
// R16: arbitration-lost bit shows lost arbitration of the message.
// R17: transmit error bit shows a bus error during the message.
// R18: attempts-exhausted flag set by hardware, stays until software clears it.
// R19: empty flag is one when nothing is queued; resets to one.
// R20: not-full flag is one while a slot is free; resets to one.
// R21: empty and not-full follow occupancy; enabled flags request interrupt.
// R22: summary bit 0 reports queue interrupt; request vector bit 0 mirrors send request. Here both share the vector register, request at bit 1.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module ctq_top (
    input  wire logic                I_CORE_CLK,
    input  wire logic                I_ARST_N,
    input  wire logic [2:0]          I_AVS_ADDRESS,
    input  wire logic                I_AVS_READ,
    input  wire logic                I_AVS_WRITE,
    input  wire logic [31:0]         I_AVS_WRITEDATA,
    input  wire logic [3:0]          I_AVS_BYTEENABLE,
    output logic      [31:0]         O_AVS_READDATA,
    output logic                     O_AVS_WAITREQUEST,
    input  wire ctq_pkg::ctq_evt_type I_TX_EVT,
    output logic                     O_TX_REQ,
    output logic                     O_ABORT_REQ,
    output logic      [4:0]          O_SLOT,
    output logic      [6:0]          O_PAYLOAD_BYTES,
    output logic      [4:0]          O_PRIORITY,
    output logic      [31:0]         O_BASE_ADDR,
    output logic                     O_TX_IRQ
);

    logic                 rst_meta_ff;
    logic                 rst_n_ff;
    logic                 wait_ff;
    logic [31:0]          rdata_ff;
    logic [31:0]          nxt_rdata;
    logic [15:0]          base_hi_ff;
    logic [15:0]          base_lo_ff;
    ctq_pkg::ctq_cfg_type cfg_ff;
    logic [2:0]           mode_ff;
    logic                 rtx_en_ff;
    logic                 flush_ff;
    logic                 req_ff;
    logic                 abort_ff;
    logic                 ie_exh_ff;
    logic                 ie_emp_ff;
    logic                 ie_nf_ff;
    logic [4:0]           head_ff;
    logic [4:0]           tail_ff;
    logic [5:0]           count_ff;
    logic [1:0]           tries_ff;
    logic                 abt_ff;
    logic                 arb_ff;
    logic                 err_ff;
    logic                 exh_ff;
    logic                 irq_ff;
    logic                 send_request_ff;
    logic [6:0]           pl_bytes_ff;
    logic                 acc;
    logic                 wr_lo;
    logic                 wr_hi;
    logic                 empty;
    logic                 not_full;
    logic                 push;
    logic                 sent;
    logic                 drop;
    logic                 fail;
    logic                 exhaust;
    logic                 pop;
    logic                 irq_cond;

    // reset release through two flops
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // one wait state: waitrequest drops in the cycle after the request is seen
    always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff  <= !((I_AVS_READ || I_AVS_WRITE) && wait_ff);
            rdata_ff <= nxt_rdata;
        end
    end

    assign acc   = I_AVS_WRITE && !wait_ff;
    assign wr_lo = acc && I_AVS_BYTEENABLE[0];
    assign wr_hi = acc && I_AVS_BYTEENABLE[1];

    assign empty    = (count_ff == 6'h00);                            // [R19] [R21]
    assign not_full = (count_ff <= {1'b0, cfg_ff.queue_depth_code});  // [R20] [R4]
    assign push     = wr_hi && (I_AVS_ADDRESS == ctq_pkg::A_CTL)
                      && I_AVS_WRITEDATA[ctq_pkg::CTL_ADV] && not_full && !flush_ff;
    assign sent     = I_TX_EVT.sent && !empty;
    assign drop     = I_TX_EVT.aborted && !empty;
    assign fail     = (I_TX_EVT.arb_lost || I_TX_EVT.bus_error) && !empty;
    // retries: none unless globally enabled or with code 00, three with code 01, otherwise unlimited
    assign exhaust  = fail && (!rtx_en_ff || cfg_ff.retry_limit_code == ctq_pkg::RETRY_NONE
                      || (cfg_ff.retry_limit_code == ctq_pkg::RETRY_THREE
                      && tries_ff == ctq_pkg::RETRY_MAX_TRIES));             // [R5]
    assign pop      = sent || drop || exhaust;
    assign irq_cond = (exh_ff && ie_exh_ff) || (empty && ie_emp_ff)
                      || (not_full && ie_nf_ff);                             // [R13] [R21]

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (I_AVS_READ && wait_ff) begin
            unique case (I_AVS_ADDRESS)
                ctq_pkg::A_BASE_HI: nxt_rdata[15:0] = base_hi_ff;          // [R1]
                ctq_pkg::A_BASE_LO: nxt_rdata[15:0] = base_lo_ff;
                ctq_pkg::A_CFG:     nxt_rdata[15:0] = {cfg_ff.payload_size_code,
                                        cfg_ff.queue_depth_code, 1'b0,
                                        cfg_ff.retry_limit_code, cfg_ff.transmit_priority};
                ctq_pkg::A_CTL: begin
                    nxt_rdata[ctq_pkg::CTL_FLUSH]  = flush_ff;
                    nxt_rdata[ctq_pkg::CTL_REQ]    = req_ff;
                    nxt_rdata[ctq_pkg::CTL_DIR]    = ctq_pkg::TX_DIR_VALUE;   // [R12]
                    nxt_rdata[ctq_pkg::CTL_EXH_IE] = ie_exh_ff;
                    nxt_rdata[ctq_pkg::CTL_EMP_IE] = ie_emp_ff;
                    nxt_rdata[ctq_pkg::CTL_NF_IE]  = ie_nf_ff;
                end
                ctq_pkg::A_STA: begin
                    nxt_rdata[ctq_pkg::STA_IDX_LSB +: 5] = tail_ff;           // [R14]
                    nxt_rdata[ctq_pkg::STA_ABT] = abt_ff;
                    nxt_rdata[ctq_pkg::STA_ARB] = arb_ff;
                    nxt_rdata[ctq_pkg::STA_ERR] = err_ff;
                    nxt_rdata[ctq_pkg::STA_EXH] = exh_ff;
                    nxt_rdata[ctq_pkg::STA_EMP] = empty;
                    nxt_rdata[ctq_pkg::STA_NF]  = not_full;
                end
                ctq_pkg::A_GLB: begin
                    nxt_rdata[ctq_pkg::GLB_MODE_LSB +: 3] = mode_ff;
                    nxt_rdata[ctq_pkg::GLB_RTX]           = rtx_en_ff;
                end
                ctq_pkg::A_VEC: begin
                    nxt_rdata[ctq_pkg::VEC_SUM] = irq_ff;                     // [R22]
                    nxt_rdata[ctq_pkg::VEC_REQ] = req_ff;                     // [R22]
                end
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // base address, configuration and global mode
    always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            base_hi_ff <= 16'h0000;
            base_lo_ff <= 16'h0000;
            cfg_ff     <= ctq_pkg::CFG_RESET;
            mode_ff    <= ctq_pkg::MODE_RESET;
            rtx_en_ff  <= 1'b0;
        end else begin
            if (I_AVS_ADDRESS == ctq_pkg::A_BASE_HI) begin
                if (wr_lo) base_hi_ff[7:0]  <= I_AVS_WRITEDATA[7:0];      // [R1]
                if (wr_hi) base_hi_ff[15:8] <= I_AVS_WRITEDATA[15:8];
            end
            if (I_AVS_ADDRESS == ctq_pkg::A_BASE_LO) begin
                if (wr_lo) base_lo_ff[7:0]  <= I_AVS_WRITEDATA[7:0]
                    & ctq_pkg::BASE_LO_MASK[7:0];                              // [R2]
                if (wr_hi) base_lo_ff[15:8] <= I_AVS_WRITEDATA[15:8];
            end
            if (I_AVS_ADDRESS == ctq_pkg::A_CFG) begin
                if (wr_lo) begin
                    cfg_ff.retry_limit_code  <= I_AVS_WRITEDATA[ctq_pkg::CFG_RETRY_LSB +: 2];
                    cfg_ff.transmit_priority <= I_AVS_WRITEDATA[ctq_pkg::CFG_PRI_LSB +: 5]; // [R6]
                end
                if (wr_hi && mode_ff == ctq_pkg::MODE_CONFIG) begin                       // [R7]
                    cfg_ff.payload_size_code <= I_AVS_WRITEDATA[ctq_pkg::CFG_PL_LSB +: 3];
                    cfg_ff.queue_depth_code  <= I_AVS_WRITEDATA[ctq_pkg::CFG_DEPTH_LSB +: 5];
                end
            end
            if (I_AVS_ADDRESS == ctq_pkg::A_GLB && wr_lo) begin
                mode_ff   <= I_AVS_WRITEDATA[ctq_pkg::GLB_MODE_LSB +: 3];
                rtx_en_ff <= I_AVS_WRITEDATA[ctq_pkg::GLB_RTX];
            end
        end
    end

    // control bits: flush, send request, abort, enables
    always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            flush_ff  <= 1'b0;
            req_ff    <= 1'b0;
            abort_ff  <= 1'b0;
            ie_exh_ff <= 1'b0;
            ie_emp_ff <= 1'b0;
            ie_nf_ff  <= 1'b0;
        end else begin
            if (flush_ff) begin
                flush_ff <= 1'b0;                                          // [R8]
                req_ff   <= 1'b0;
                abort_ff <= 1'b0;
            end else begin
                if (pop && count_ff == 6'h01 && !push) req_ff <= 1'b0;     // [R9]
                if (drop || exhaust || sent) abort_ff <= 1'b0;
                if (wr_hi && I_AVS_ADDRESS == ctq_pkg::A_CTL) begin
                    flush_ff <= I_AVS_WRITEDATA[ctq_pkg::CTL_FLUSH];       // [R8]
                    if (I_AVS_WRITEDATA[ctq_pkg::CTL_REQ]) req_ff <= 1'b1; // [R9]
                    else if (req_ff) begin
                        req_ff   <= 1'b0;
                        abort_ff <= 1'b1;                                  // [R10]
                    end
                end
            end
            if (wr_lo && I_AVS_ADDRESS == ctq_pkg::A_CTL) begin
                ie_exh_ff <= I_AVS_WRITEDATA[ctq_pkg::CTL_EXH_IE];         // [R13]
                ie_emp_ff <= I_AVS_WRITEDATA[ctq_pkg::CTL_EMP_IE];
                ie_nf_ff  <= I_AVS_WRITEDATA[ctq_pkg::CTL_NF_IE];
            end
        end
    end

    // queue pointers and occupancy
    always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            head_ff  <= 5'h00;
            tail_ff  <= 5'h00;
            count_ff <= 6'h00;
            tries_ff <= 2'h0;
        end else if (flush_ff) begin
            head_ff  <= 5'h00;                                             // [R8]
            tail_ff  <= 5'h00;
            count_ff <= 6'h00;
            tries_ff <= 2'h0;
        end else begin
            if (push) begin
                head_ff <= (head_ff == cfg_ff.queue_depth_code) ? 5'h00 : head_ff + 5'h01; // [R11]
            end
            if (pop) begin
                tail_ff  <= (tail_ff == cfg_ff.queue_depth_code) ? 5'h00   // [R14]
                            : tail_ff + 5'h01;
                tries_ff <= 2'h0;
            end else if (fail && tries_ff != ctq_pkg::RETRY_MAX_TRIES) begin
                tries_ff <= tries_ff + 2'h1;                               // [R5]
            end
            count_ff <= count_ff + {5'h00, push} - {5'h00, pop};           // [R11]
        end
    end

    // outcome status and the attempts-exhausted flag
    always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            abt_ff <= 1'b0;
            arb_ff <= 1'b0;
            err_ff <= 1'b0;
            exh_ff <= 1'b0;
        end else begin
            if (flush_ff || sent) abt_ff <= 1'b0;                          // [R15]
            else if (drop || exhaust) abt_ff <= 1'b1;                      // [R15]
            if (flush_ff || sent) arb_ff <= 1'b0;
            else if (fail && I_TX_EVT.arb_lost) arb_ff <= 1'b1;            // [R16]
            if (flush_ff || sent) err_ff <= 1'b0;
            else if (fail && I_TX_EVT.bus_error) err_ff <= 1'b1;           // [R17]
            // set wins over a software clear in the same cycle
            if (exhaust) exh_ff <= 1'b1;                                   // [R18]
            else if (wr_lo && I_AVS_ADDRESS == ctq_pkg::A_STA
                     && !I_AVS_WRITEDATA[ctq_pkg::STA_EXH]) exh_ff <= 1'b0; // [R18]
        end
    end

    // registered outputs toward the engine and the interrupt controller
    always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_ff      <= 1'b0;
            send_request_ff    <= 1'b0;
            pl_bytes_ff <= 7'h08;
        end else begin
            irq_ff      <= irq_cond;                                       // [R22]
            send_request_ff    <= req_ff && !empty && !flush_ff;
            pl_bytes_ff <= ctq_pkg::payload_bytes(cfg_ff.payload_size_code); // [R3]
        end
    end

    assign O_AVS_READDATA    = rdata_ff;
    assign O_AVS_WAITREQUEST = wait_ff;
    assign O_TX_REQ          = send_request_ff;
    assign O_ABORT_REQ       = abort_ff;
    assign O_SLOT            = tail_ff;
    assign O_PAYLOAD_BYTES   = pl_bytes_ff;
    assign O_PRIORITY        = cfg_ff.transmit_priority;
    assign O_BASE_ADDR       = {base_hi_ff, base_lo_ff};
    assign O_TX_IRQ          = irq_ff;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!rst_n_ff);

    AST_BASE_ALIGN: assert property (base_lo_ff[1:0] == 2'h0) // [R2]
        else $error("base address low bits not zero");
    AST_CFG_LOCK: assert property (wr_hi && I_AVS_ADDRESS == ctq_pkg::A_CFG // [R7]
        && mode_ff != ctq_pkg::MODE_CONFIG
        |=> $stable(cfg_ff.queue_depth_code) && $stable(cfg_ff.payload_size_code))
        else $error("size fields changed outside configuration mode");
    AST_FLUSH_DONE: assert property (flush_ff |=> !flush_ff && count_ff == 6'h00 // [R8]
        && !req_ff && tail_ff == 5'h00)
        else $error("flush did not empty the queue in one cycle");
    AST_REQ_AUTOCLR: assert property (req_ff && !flush_ff && pop && count_ff == 6'h01 // [R9]
        && !push && !acc |=> !req_ff)
        else $error("send request not cleared on drain");
    AST_ABORT_REQ: assert property (req_ff && !flush_ff && wr_hi // [R10]
        && I_AVS_ADDRESS == ctq_pkg::A_CTL && !I_AVS_WRITEDATA[ctq_pkg::CTL_REQ]
        |=> abort_ff ##0 !req_ff)
        else $error("clearing send request did not raise abort");
    AST_HEAD_STEP: assert property (push && !pop |=> count_ff == $past(count_ff) + 6'h01) // [R11]
        else $error("head advance did not add exactly one message");
    AST_SLOT_RANGE: assert property (count_ff <= {1'b0, cfg_ff.queue_depth_code} + 6'h01 // [R14]
        |-> tail_ff <= cfg_ff.queue_depth_code || count_ff == 6'h00)
        else $error("next slot index beyond depth");
    AST_EXH_STICKY: assert property (exh_ff // [R18]
        && !(wr_lo && I_AVS_ADDRESS == ctq_pkg::A_STA) |=> exh_ff)
        else $error("exhausted flag dropped without software clear");
    AST_EXH_SET: assert property (exhaust && !flush_ff |=> exh_ff ##0 abt_ff) // [R18]
        else $error("exhausted event not flagged");
    AST_SENT_CLEAR: assert property (sent && !flush_ff |=> !abt_ff && !arb_ff && !err_ff) // [R15]
        else $error("status not cleared on successful send");
    AST_BUS_ANSWER: assert property ((I_AVS_READ || I_AVS_WRITE) && wait_ff |=> !wait_ff)
        else $error("avalon answer late");

    COV_FLUSH: cover property (flush_ff ##1 empty);
    COV_EXHAUST: cover property (exhaust);
    COV_ABORT: cover property (abort_ff ##[1:20] drop);
    COV_FULL: cover property (!not_full ##[1:50] sent);

endmodule // ctq_top

// ---- bench/ctq_engine_model.sv ----
// ctq_engine_model: protocol engine stand-in answering each attempt with one event pulse; in mode 3 only an abort is answered.
// assumes the bench sets outcome and delay before it raises a send request.
`timescale 1ns/1ps
module ctq_engine_model (
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire logic            i_tx_req,
    input  wire logic            i_abort_req,
    input  wire logic [1:0]      i_mode,
    input  wire logic [3:0]      i_delay,
    output ctq_pkg::ctq_evt_type o_evt
);
    logic [3:0] cnt_ff;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 4'h0;
            o_evt  <= '0;
        end else begin
            o_evt  <= '0;
            cnt_ff <= (i_tx_req || i_abort_req) ? cnt_ff + 4'h1 : 4'h0;
            if ((i_tx_req || i_abort_req) && cnt_ff == i_delay) begin
                cnt_ff <= 4'h0;
                // mode 3 stalls until an abort is asked for
                if (i_abort_req) o_evt.aborted <= 1'b1;
                else if (i_mode == 2'h0) o_evt.sent <= 1'b1;
                else if (i_mode == 2'h1) o_evt.arb_lost <= 1'b1;
                else if (i_mode == 2'h2) o_evt.bus_error <= 1'b1;
            end
        end
    end
endmodule // ctq_engine_model

// ---- bench/can_fd_tx_queue_control_test.sv ----
// can_fd_tx_queue_control_test: register and queue scenarios with a read scoreboard.
// assumes ctq_top with one wait state per access and the engine model beside it.
`timescale 1ns/1ps
module can_fd_tx_queue_control_test;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [31:0] rdata, base;
    logic        waitreq, tx_req, abort_req, irq;
    logic [4:0]  slot, prio;
    logic [6:0]  pbytes;
    logic [1:0]  m_mode = 2'h0;
    logic [3:0]  m_dly = 4'h2;
    logic [15:0] seed = 16'h0061;
    logic [15:0] v;
    logic [15:0] expq[$];
    ctq_pkg::ctq_evt_type evt;
    int mismatches = 0;
    int compares = 0;
    int fails = 0;
    localparam logic [15:0] RST_EXP [8] = '{16'h0000, 16'h0000, 16'h0060, 16'h0000,
                                            16'h0005, 16'h0004, 16'h0000, 16'h0000};
    localparam logic [6:0] PL_EXP [8] = '{7'h08, 7'h0C, 7'h10, 7'h14,
                                          7'h18, 7'h20, 7'h30, 7'h40};

    always #2.5 clk = ~clk;

    ctq_top DUT (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_TX_EVT(evt),
        .O_TX_REQ(tx_req), .O_ABORT_REQ(abort_req), .O_SLOT(slot),
        .O_PAYLOAD_BYTES(pbytes), .O_PRIORITY(prio), .O_BASE_ADDR(base), .O_TX_IRQ(irq));

    ctq_engine_model MDL (.i_clk(clk), .i_rst_n(arst_n), .i_tx_req(tx_req),
        .i_abort_req(abort_req), .i_mode(m_mode), .i_delay(m_dly), .o_evt(evt));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic test_done();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic r, input logic [2:0] a, input logic [15:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        rd    <= r;
        wr    <= !r;
        wdata <= {16'h0000, d};
        be    <= b;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitreq !== 1'b0) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic wrt(input logic [2:0] a, input logic [15:0] d, input logic [3:0] b);
        bus(1'b0, a, d, b);
    endtask

    task automatic rdx(input logic [2:0] a, input logic [15:0] e);
        expq.push_back(e);
        bus(1'b1, a, 16'h0000, 4'hF);
    endtask

    task automatic wait_tx(input logic val);
        int n;
        n = 0;
        while (tx_req !== val && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (tx_req !== val) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic req_after_advance();
        wrt(ctq_pkg::A_CTL, 16'h0100, 4'h2);
        wrt(ctq_pkg::A_CTL, 16'h0200, 4'h2);
        wait_tx(1'b1);
    endtask

    // read data stands at the edge where waitrequest is low
    always @(posedge clk) begin
        if (rd && waitreq === 1'b0) chk(rdata, {16'h0000, expq.pop_front()});
        if (evt.arb_lost || evt.bus_error) fails++;
    end

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) rdx(i[2:0], RST_EXP[i]);
        wrt(ctq_pkg::A_CTL, 16'h0080, 4'h1);
        wrt(ctq_pkg::A_STA, 16'hFFFF, 4'h3);
        rdx(ctq_pkg::A_CTL, 16'h0000);
        rdx(ctq_pkg::A_STA, 16'h0005);
        $display("test reset done");
        seed = lfsr(seed);
        wrt(ctq_pkg::A_BASE_LO, 16'hFFFF, 4'h3);
        wrt(ctq_pkg::A_BASE_HI, seed, 4'h3);
        rdx(ctq_pkg::A_BASE_LO, 16'hFFFC);
        rdx(ctq_pkg::A_BASE_HI, seed);
        chk(base, {seed, 16'hFFFC});
        $display("test base done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = {i[2:0], 5'h03, 1'b0, 2'h1, seed[4:0]};
            wrt(ctq_pkg::A_CFG, v, 4'h3);
            rdx(ctq_pkg::A_CFG, v);
            chk({25'h0, pbytes}, {25'h0, PL_EXP[i]});
            chk({27'h0, prio}, {27'h0, seed[4:0]});
        end
        wrt(ctq_pkg::A_GLB, 16'h0010, 4'h3);
        wrt(ctq_pkg::A_CFG, 16'h003F, 4'h3);
        rdx(ctq_pkg::A_CFG, 16'hE33F);
        $display("test config done");
        repeat (3) wrt(ctq_pkg::A_CTL, 16'h0100, 4'h2);
        rdx(ctq_pkg::A_STA, 16'h0001);
        repeat (2) wrt(ctq_pkg::A_CTL, 16'h0100, 4'h2);
        rdx(ctq_pkg::A_STA, 16'h0000);
        wrt(ctq_pkg::A_CTL, 16'h0400, 4'h2);
        rdx(ctq_pkg::A_CTL, 16'h0000);
        rdx(ctq_pkg::A_STA, 16'h0005);
        $display("test fill done");
        m_dly <= 4'hC;
        wrt(ctq_pkg::A_CTL, 16'h0100, 4'h2);
        req_after_advance();
        rdx(ctq_pkg::A_VEC, 16'h0002);
        wait_tx(1'b0);
        rdx(ctq_pkg::A_CTL, 16'h0000);
        rdx(ctq_pkg::A_STA, 16'h0205);
        chk({27'h0, slot}, 32'h2);
        $display("test send done");
        m_mode <= 2'h1;
        m_dly <= 4'h2;
        fails = 0;
        req_after_advance();
        wait_tx(1'b0);
        chk(fails, 32'h4);
        rdx(ctq_pkg::A_STA, 16'h03D5);
        wrt(ctq_pkg::A_CTL, 16'h0010, 4'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wrt(ctq_pkg::A_STA, 16'h0000, 4'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wrt(ctq_pkg::A_CTL, 16'h0004, 4'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        $display("test exhaust done");
        m_mode <= 2'h1;
        m_dly <= 4'h3;
        fails = 0;
        wrt(ctq_pkg::A_CFG, 16'h007F, 4'h1);
        req_after_advance();
        repeat (30) @(posedge clk);
        chk({31'h0, fails > 4}, 32'h1);
        wrt(ctq_pkg::A_CTL, 16'h0000, 4'h2);
        @(posedge clk);
        chk({31'h0, abort_req}, 32'h1);
        repeat (10) @(posedge clk);
        chk({30'h0, abort_req, tx_req}, 32'h0);
        rdx(ctq_pkg::A_STA, 16'h00C5);
        $display("test abort done");
        wrt(ctq_pkg::A_CTL, 16'h0400, 4'h2);
        wrt(ctq_pkg::A_GLB, 16'h0000, 4'h3);
        m_mode <= 2'h2;
        fails = 0;
        req_after_advance();
        wait_tx(1'b0);
        chk(fails, 32'h1);
        rdx(ctq_pkg::A_STA, 16'h01B5);
        wrt(ctq_pkg::A_GLB, 16'h0010, 4'h3);
        wrt(ctq_pkg::A_CFG, 16'h001F, 4'h1);
        fails = 0;
        req_after_advance();
        wait_tx(1'b0);
        chk(fails, 32'h1);
        $display("test error done");
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule // can_fd_tx_queue_control_test
